/* File: design/mcf_path.sv */
// Purpose: Three-channel sinc3 front end with droop, phase, gain/offset and DC filters.
// Assumes: Modulator bits are synchronous to i_clk and held for 8 clocks each.
// Notes: Paths are 0 first_voltage_path, 1 current 1, 2 second_voltage_path, 3 current 2.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns

// Function
// - take each modulator bit every eighth clock
// - sinc3 decimate to 24-bit words, clock/1024
// - droop IIR flattens response after decimation
// - droop filter on at reset, bypass bit
// - voltage word feeds two independent paths
// - phase delay inside decimation, coarse plus fine
// - fine field delays current up to one period
// - coarse adds one (current) or two periods
// - span plus/minus two periods, fine steps
// - each path owns gain and offset
// - offset and gain correct every sample
// - optional per-path DC removal filter
// - DC removal corner near 2 Hz
module mcf_path (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_mod_voltage,
	input wire logic i_mod_current1,
	input wire logic i_mod_current2,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic o_waitrequest,
	output logic [31:0] o_readdata
);
	typedef struct packed {
		logic [9:0] frame;
		logic [2:0][2:0][23:0] integ;
		logic [2:0][2:0][23:0] cprev;
		logic [2:0][2:0][23:0] hist;
		logic [3:0][23:0] work;
		logic [3:0][23:0] droop_y;
		logic [3:0][23:0] lp;
		logic [3:0][23:0] lps;
		mcf_pkg::mcf_state_e state;
		logic [8:0] cfg2;
		logic [25:0] phase;
		logic [3:0][23:0] offset;
		logic [3:0][23:0] gain;
		logic wait_r;
		logic [31:0] rdata;
		logic pend_valid;
		logic [95:0] pend;
		logic overrun;
	} mcf_path_s;

	mcf_path_s s_r;
	mcf_path_s s_nxt;
	logic fifo_wr_ready;
	logic fifo_rd_valid;
	logic fifo_pop;
	logic [95:0] fifo_rd_data;

	// Sign-extend a 24-bit word for wide arithmetic
	function automatic logic signed [49:0] sx(input logic [23:0] x);
		return $signed({{26{x[23]}}, x});
	endfunction : sx

	// Clamp a wide result back into a signed 24-bit word
	function automatic logic [23:0] sat(input logic signed [49:0] v);
		logic [23:0] r;
		if (v > mcf_pkg::SAT_HI) begin
			r = 24'h7fffff;
		end else if (v < mcf_pkg::SAT_LO) begin
			r = 24'h800000;
		end else begin
			r = v[23:0];
		end
		return r;
	endfunction : sat

	// Offset first, then gain with 22 fractional bits
	function automatic logic [23:0] corr(input logic [23:0] x, input logic [23:0] off, input logic [23:0] g);
		logic signed [49:0] a;
		logic signed [49:0] p;
		a = sx(x) + sx(off);
		p = a * $signed({26'h0000000, g});
		return sat(p >>> mcf_pkg::GAIN_FRAC);
	endfunction : corr

	// First-order smoother: y + (x - y) / 2^k
	function automatic logic [23:0] smooth(input logic [23:0] y, input logic [23:0] x, input int unsigned k);
		return sat(sx(y) + ((sx(x) - sx(y)) >>> k));
	endfunction : smooth

	// Byte-lane merge of a write into a register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// Converter channel behind each path: the voltage word serves paths 0 and 2
	function automatic int unsigned chan_of(input int unsigned p);
		return (p == 0 || p == 2) ? 0 : (p == 1 ? 1 : 2);
	endfunction : chan_of

	// Coarse code of a path, clamped to its channel's limit
	function automatic logic [1:0] coarse_of(input logic [25:0] ph, input int unsigned p);
		logic [1:0] c;
		logic [1:0] lim;
		c = ph[2*p +: 2];
		lim = (p == 0 || p == 2) ? mcf_pkg::COARSE_MAX_V : mcf_pkg::COARSE_MAX_I;
		return (c > lim) ? lim : c;
	endfunction : coarse_of

	mcf_fifo #(
		.W(96),
		.DEPTH(8)
	) u_fifo (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_wr_valid(s_r.pend_valid),
		.o_wr_ready(fifo_wr_ready),
		.i_wr_data(s_r.pend),
		.o_rd_valid(fifo_rd_valid),
		.i_rd_ready(fifo_pop),
		.o_rd_data(fifo_rd_data)
	);

	assign o_waitrequest = s_r.wait_r;
	assign o_readdata = s_r.rdata;

	// Whole datapath, register file and bus answer
	always_comb begin
		logic [2:0] mod_bit;
		logic [2:0][8:0] fine;
		logic [9:0] dec_at;
		logic [23:0] c1;
		logic [23:0] c2;
		logic [23:0] c3;
		logic [23:0] y;
		logic [23:0] hp;
		logic [1:0] mode;
		logic [95:0] outw;
		logic [31:0] rd;
		logic [31:0] wv;
		logic [1:0] pi;
		mod_bit = {i_mod_current2, i_mod_current1, i_mod_voltage};
		fine = {s_r.phase[mcf_pkg::PH_FINE2_LSB +: 9], s_r.phase[mcf_pkg::PH_FINE1_LSB +: 9], 9'h000};
		dec_at = '0;
		c1 = '0;
		c2 = '0;
		c3 = '0;
		y = '0;
		hp = '0;
		mode = '0;
		outw = '0;
		rd = '0;
		wv = '0;
		pi = i_address[3:2];
		fifo_pop = 1'b0;
		s_nxt = s_r;
		s_nxt.frame = s_r.frame + 10'h001;

		// Integrators run at the modulator rate, one bit per 8 clocks
		for (int ch = 0; ch < 3; ch++) begin
			if (s_r.frame[2:0] == mcf_pkg::SAMPLE_PHASE) begin
				s_nxt.integ[ch][0] = s_r.integ[ch][0] + (mod_bit[ch] ? mcf_pkg::BIT_ONE : mcf_pkg::BIT_MINUS_ONE);
				s_nxt.integ[ch][1] = s_r.integ[ch][1] + s_r.integ[ch][0];
				s_nxt.integ[ch][2] = s_r.integ[ch][2] + s_r.integ[ch][1];
			end
			// Fine delay moves the decimation instant earlier, 2 clocks per code
			dec_at = mcf_pkg::DEC_POS - {fine[ch], 1'b0};
			if (s_r.frame == dec_at) begin
				c1 = s_r.integ[ch][2] - s_r.cprev[ch][0];
				c2 = c1 - s_r.cprev[ch][1];
				c3 = c2 - s_r.cprev[ch][2];
				s_nxt.cprev[ch][0] = s_r.integ[ch][2];
				s_nxt.cprev[ch][1] = c1;
				s_nxt.cprev[ch][2] = c2;
				// Two older words kept for the coarse delay
				s_nxt.hist[ch][2] = s_r.hist[ch][1];
				s_nxt.hist[ch][1] = s_r.hist[ch][0];
				s_nxt.hist[ch][0] = c3;
			end
		end

		// Finished word leaves for the FIFO when it has room
		if (s_r.pend_valid && fifo_wr_ready) begin
			s_nxt.pend_valid = 1'b0;
		end

		// Bus: answer one cycle after the request, act at the completing edge
		s_nxt.wait_r = 1'b1;
		if ((i_read || i_write) && s_r.wait_r) begin
			if (i_address == mcf_pkg::ADDR_CFG2) begin
				rd = {23'h000000, s_r.cfg2};
			end else if (i_address == mcf_pkg::ADDR_PHASE) begin
				rd = {6'h00, s_r.phase};
			end else if (i_address == mcf_pkg::ADDR_STATUS) begin
				rd[mcf_pkg::ST_DATA_BIT] = fifo_rd_valid;
				rd[mcf_pkg::ST_OVERRUN_BIT] = s_r.overrun;
				rd[mcf_pkg::ST_PEND_BIT] = s_r.pend_valid;
			end else if (i_address[7:4] == mcf_pkg::PAGE_OFFSET && i_address[1:0] == 2'h0) begin
				rd = {8'h00, s_r.offset[pi]};
			end else if (i_address[7:4] == mcf_pkg::PAGE_GAIN && i_address[1:0] == 2'h0) begin
				rd = {8'h00, s_r.gain[pi]};
			end else if (i_address[7:4] == mcf_pkg::PAGE_RESULT && i_address[1:0] == 2'h0) begin
				rd = fifo_rd_valid ? {8'h00, fifo_rd_data[24*pi +: 24]} : 32'h00000000;
			end else begin
				rd = 32'h00000000;
			end
			s_nxt.rdata = rd;
			s_nxt.wait_r = 1'b0;
		end else if (i_write && !s_r.wait_r) begin
			if (i_address == mcf_pkg::ADDR_CFG2) begin
				wv = merge({23'h000000, s_r.cfg2}, i_writedata, i_byteenable);
				s_nxt.cfg2 = wv[mcf_pkg::CFG_WIDTH-1:0];
			end else if (i_address == mcf_pkg::ADDR_PHASE) begin
				wv = merge({6'h00, s_r.phase}, i_writedata, i_byteenable);
				s_nxt.phase = wv[mcf_pkg::PH_WIDTH-1:0];
			end else if (i_address == mcf_pkg::ADDR_STATUS) begin
				if (i_byteenable[0] && i_writedata[mcf_pkg::ST_OVERRUN_BIT]) begin
					s_nxt.overrun = 1'b0;
				end
			end else if (i_address[7:4] == mcf_pkg::PAGE_OFFSET && i_address[1:0] == 2'h0) begin
				wv = merge({8'h00, s_r.offset[pi]}, i_writedata, i_byteenable);
				s_nxt.offset[pi] = wv[23:0];
			end else if (i_address[7:4] == mcf_pkg::PAGE_GAIN && i_address[1:0] == 2'h0) begin
				wv = merge({8'h00, s_r.gain[pi]}, i_writedata, i_byteenable);
				s_nxt.gain[pi] = wv[23:0];
			end
		end else if (i_read && !s_r.wait_r) begin
			// Reading the last result word retires the whole set of four
			if (i_address[7:4] == mcf_pkg::PAGE_RESULT && i_address[1:0] == 2'h0 && pi == mcf_pkg::LAST_PATH) begin
				fifo_pop = fifo_rd_valid;
			end
		end

		// Word pipeline: one stage per clock after the frame strobe
		case (s_r.state)
			mcf_pkg::ST_IDLE: begin
				if (s_r.frame == mcf_pkg::STROBE_POS) begin
					for (int p = 0; p < 4; p++) begin
						// Delayed word picked from the channel's history
						s_nxt.work[p] = s_r.hist[chan_of(p)][coarse_of(s_r.phase, p)];
					end
					s_nxt.state = mcf_pkg::ST_DROOP;
				end
			end
			mcf_pkg::ST_DROOP: begin
				for (int p = 0; p < 4; p++) begin
					// Boost of high frequencies; unity at DC keeps calibration valid
					y = sat(sx(s_r.work[p]) + ((sx(s_r.work[p]) - sx(s_r.droop_y[p])) >>> mcf_pkg::DROOP_SHIFT));
					if (s_r.cfg2[mcf_pkg::CFG_BYPASS_BIT]) begin
						y = s_r.work[p];
					end
					s_nxt.droop_y[p] = y;
					s_nxt.work[p] = y;
				end
				s_nxt.state = mcf_pkg::ST_CORR;
			end
			mcf_pkg::ST_CORR: begin
				for (int p = 0; p < 4; p++) begin
					s_nxt.work[p] = corr(s_r.work[p], s_r.offset[p], s_r.gain[p]);
				end
				s_nxt.state = mcf_pkg::ST_FILT;
			end
			mcf_pkg::ST_FILT: begin
				for (int p = 0; p < 4; p++) begin
					mode = s_r.cfg2[mcf_pkg::CFG_MODE_LSB + 2*p +: 2];
					// High-pass is the input less a running mean, corner near 2 Hz
					s_nxt.lp[p] = smooth(s_r.lp[p], s_r.work[p], mcf_pkg::HPF_SHIFT);
					s_nxt.lps[p] = smooth(s_r.lps[p], s_r.work[p], mcf_pkg::PMF_SHIFT);
					hp = sat(sx(s_r.work[p]) - sx(s_nxt.lp[p]));
					if (mode == mcf_pkg::MODE_HPF) begin
						outw[24*p +: 24] = hp;
					end else if (mode == mcf_pkg::MODE_PMF) begin
						// Same phase lead as the high-pass, DC restored by a slower mean
						outw[24*p +: 24] = sat(sx(hp) + sx(s_nxt.lps[p]));
					end else begin
						outw[24*p +: 24] = s_r.work[p];
					end
				end
				// A word that finds the output stage still full is dropped and flagged
				if (s_nxt.pend_valid) begin
					s_nxt.overrun = 1'b1;
				end else begin
					s_nxt.pend = outw;
					s_nxt.pend_valid = 1'b1;
				end
				s_nxt.state = mcf_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.state = mcf_pkg::ST_IDLE;
			end
		endcase
	end

	// Single state register; gains start at unity, droop filter enabled
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '0;
			s_r.state <= mcf_pkg::ST_IDLE;
			s_r.gain <= {4{mcf_pkg::GAIN_ONE}};
			s_r.wait_r <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : mcf_path

/* File: design/mcf_pkg.sv */
// Purpose: Shared constants and types for the metering channel filter path.
// Assumes: The master clock is the module clock; one output word every 1024 clocks.
// Notes: Byte addresses are for an Avalon-MM slave with 32-bit data.
package mcf_pkg;
	// Word widths and frame timing
	localparam int unsigned DW = 24;
	localparam logic [9:0] STROBE_POS = 10'h3ff; // Last clock of a 1024-clock word frame
	localparam logic [9:0] DEC_POS = 10'h3fe; // Decimation instant with zero fine delay
	localparam logic [2:0] SAMPLE_PHASE = 3'h0; // Modulator bit taken once per 8 clocks
	localparam logic [23:0] BIT_ONE = 24'h000001;
	localparam logic [23:0] BIT_MINUS_ONE = 24'hffffff;
	// Filter shifts: droop boost, 2 Hz high-pass corner, slower phase-matching term
	localparam int unsigned DROOP_SHIFT = 2;
	localparam int unsigned HPF_SHIFT = 8;
	localparam int unsigned PMF_SHIFT = 12;
	localparam int unsigned GAIN_FRAC = 22;
	localparam logic [23:0] GAIN_ONE = 24'h400000;
	localparam logic signed [49:0] SAT_HI = 50'sh00000007fffff;
	localparam logic signed [49:0] SAT_LO = -50'sh0000000800000;
	// Register byte addresses
	localparam logic [7:0] ADDR_CFG2 = 8'h00;
	localparam logic [7:0] ADDR_PHASE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [3:0] PAGE_OFFSET = 4'h1;
	localparam logic [3:0] PAGE_GAIN = 4'h2;
	localparam logic [3:0] PAGE_RESULT = 4'h3;
	localparam logic [1:0] LAST_PATH = 2'h3;
	// Field positions
	localparam int unsigned CFG_BYPASS_BIT = 0;
	localparam int unsigned CFG_MODE_LSB = 1;
	localparam int unsigned CFG_WIDTH = 9;
	localparam int unsigned PH_FINE1_LSB = 8;
	localparam int unsigned PH_FINE2_LSB = 17;
	localparam int unsigned PH_WIDTH = 26;
	localparam int unsigned ST_DATA_BIT = 0;
	localparam int unsigned ST_OVERRUN_BIT = 1;
	localparam int unsigned ST_PEND_BIT = 2;
	// Per-path filter modes and coarse delay limits
	localparam logic [1:0] MODE_HPF = 2'h1;
	localparam logic [1:0] MODE_PMF = 2'h2;
	localparam logic [1:0] COARSE_MAX_V = 2'h2;
	localparam logic [1:0] COARSE_MAX_I = 2'h1;
	// Word pipeline states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_DROOP = 5'b00010,
		ST_CORR = 5'b00100,
		ST_FILT = 5'b01000,
		ST_SPARE = 5'b10000
	} mcf_state_e;
endpackage : mcf_pkg

/* File: design/mcf_fifo.sv */
// Purpose: Result FIFO with parameter width and depth, valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Head word sits in an output register, so one extra word fits beyond DEPTH.
`timescale 1ns/1ns
module mcf_fifo #(
	parameter int unsigned W = 96,
	parameter int unsigned DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [W-1:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [W-1:0] o_rd_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} mcf_fifo_s;
	mcf_fifo_s s_r;
	mcf_fifo_s s_nxt;
	logic do_w;
	logic pop;
	logic load;

	// Full is honest: writer stalls while the array holds DEPTH words
	assign o_wr_ready = (s_r.cnt != (AW+1)'(DEPTH));
	assign o_rd_valid = s_r.ov;
	assign o_rd_data = s_r.od;

	// Array write, head refill and occupancy
	always_comb begin
		s_nxt = s_r;
		do_w = i_wr_valid && o_wr_ready;
		pop = s_r.ov && i_rd_ready;
		load = (!s_r.ov || pop) && (s_r.cnt != '0);
		if (do_w) begin
			s_nxt.mem[s_r.wp] = i_wr_data;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (load) begin
			s_nxt.od = s_r.mem[s_r.rp];
			s_nxt.rp = s_r.rp + 1'b1;
			s_nxt.ov = 1'b1;
		end else if (pop) begin
			s_nxt.ov = 1'b0;
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(do_w) - (AW+1)'(load);
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : mcf_fifo

/* File: testbench/mcf_mod_model.sv */
// Purpose: Modulator model, three single-bit streams.
// Assumes: Level input is a per-channel bit density of all ones or all zeros.
// Notes: Bits change mid-slot so they hold 8 clocks around each sample.
`timescale 1ns/1ns
module mcf_mod_model (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [2:0] i_level,
	output logic o_mod_voltage,
	output logic o_mod_current1,
	output logic o_mod_current2
);
	logic [2:0] slot_r;
	// Update only at slot middle, away from the sampling clock
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			slot_r <= 3'h0;
			{o_mod_voltage, o_mod_current1, o_mod_current2} <= 3'h0;
		end else begin
			slot_r <= slot_r + 3'h1;
			if (slot_r == 3'h4) begin
				{o_mod_voltage, o_mod_current1, o_mod_current2} <= i_level;
			end
		end
	end
endmodule : mcf_mod_model

/* File: testbench/mcf_path_sva.sv */
// Purpose: Bus and register checks for the filter path.
// Assumes: Writes use all byte lanes.
// Notes: Shadows follow full-word writes only.
`timescale 1ns/1ns
module mcf_path_sva (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	input wire logic o_waitrequest,
	input wire logic [31:0] o_readdata
);
	logic [8:0] cfg_r;
	logic [23:0] gain1_r;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Shadow copies so read-back can be tied to the last write
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_r <= 9'h000;
			gain1_r <= 24'h400000;
		end else if (i_write && !o_waitrequest && i_byteenable == 4'hf) begin
			if (i_address == mcf_pkg::ADDR_CFG2) cfg_r <= i_writedata[8:0];
			if (i_address == 8'h24) gain1_r <= i_writedata[23:0];
		end
	end
	AST_REQ_ANSWER: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("request not answered in one cycle");
	AST_WAIT_ONE: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low longer than one cycle");
	AST_WAIT_CAUSE: assert property (!o_waitrequest |-> $past(i_read || i_write))
		else $error("waitrequest low without request");
	AST_RD_HOLD: assert property (!(i_read || i_write) |=> $stable(o_readdata))
		else $error("readdata changed while idle");
	AST_UNMAPPED: assert property (i_read && !o_waitrequest && i_address == 8'h0c |-> o_readdata == 32'h0)
		else $error("unmapped read not zero");
	AST_CFG_RB: assert property (i_read && !o_waitrequest && i_address == 8'h00 |-> o_readdata[8:0] == cfg_r)
		else $error("config read-back wrong");
	AST_GAIN_RB: assert property (i_read && !o_waitrequest && i_address == 8'h24 |-> o_readdata[23:0] == gain1_r)
		else $error("gain read-back wrong");
	AST_RST_REL: assert property ($rose(i_arst_n) |-> o_waitrequest && o_readdata == 32'h0)
		else $error("bus outputs wrong after reset");
endmodule : mcf_path_sva
bind mcf_path mcf_path_sva u_sva (.*);

/* File: testbench/mcf_path_tb.sv */
// Purpose: Self-checking bench for the filter path.
// Assumes: One result set per 1024 clocks.
// Notes: Step tests compare paths set by set, so no filter model is needed.
`timescale 1ns/1ns
module mcf_path_tb;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_address = 8'h00;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [3:0] i_byteenable = 4'hf;
	logic [2:0] level = 3'h7;
	logic mv, mc1, mc2, o_waitrequest;
	logic [31:0] o_readdata, q;
	logic [31:0] seed = 32'd99142;
	logic [23:0] res [0:7][0:3];
	logic [23:0] offs [0:3];
	logic [23:0] gains [0:3];
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	int n;
	always #5 i_clk = ~i_clk;
	mcf_path dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_mod_voltage(mv), .i_mod_current1(mc1),
		.i_mod_current2(mc2), .i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_waitrequest(o_waitrequest),
		.o_readdata(o_readdata));
	mcf_mod_model u_mod (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_level(level), .o_mod_voltage(mv),
		.o_mod_current1(mc1), .o_mod_current2(mc2));
	task automatic print_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	// Hang guard, about twice the expected run
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// One access; held until waitrequest is seen low, only the hang guard ends a wait
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_write <= wr;
		i_read <= !wr;
		i_address <= a;
		i_writedata <= d;
		do begin
			@(posedge i_clk);
		end while (o_waitrequest !== 1'b0);
		q = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask : bus
	task automatic get_set(input int j);
		do begin
			bus(1'b0, mcf_pkg::ADDR_STATUS, 32'h0);
		end while (q[0] !== 1'b1);
		for (int p = 0; p < 4; p++) begin
			bus(1'b0, 8'h30 + 8'(4 * p), 32'h0);
			res[j][p] = q[23:0];
		end
	endtask : get_set
	// Empty the FIFO, counting sets, then take k fresh sets
	task automatic fresh(input int k);
		n = 0;
		bus(1'b0, mcf_pkg::ADDR_STATUS, 32'h0);
		while (q[0] === 1'b1) begin
			bus(1'b0, 8'h3c, 32'h0);
			n++;
			bus(1'b0, mcf_pkg::ADDR_STATUS, 32'h0);
		end
		for (int j = 0; j < k; j++) get_set(j);
	endtask : fresh
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	function automatic logic [23:0] corr(input logic [23:0] x, input logic [23:0] o, input logic [23:0] g);
		longint p;
		p = ((longint'(signed'(x)) + longint'(signed'(o))) * longint'(g)) >>> 22;
		if (p > 64'sh7fffff) p = 64'sh7fffff;
		if (p < -64'sh800000) p = -64'sh800000;
		return p[23:0];
	endfunction : corr
	initial begin
		repeat (20) @(posedge i_clk);
		i_arst_n <= 1'b1;
		// Reset values, then an unmapped place
		for (int p = 0; p < 4; p++) begin
			bus(1'b0, 8'h10 + 8'(4 * p), 32'h0);
			check("offset", q[23:0], 24'h0);
			bus(1'b0, 8'h20 + 8'(4 * p), 32'h0);
			check("gain", q[23:0], 24'h400000);
		end
		bus(1'b0, mcf_pkg::ADDR_CFG2, 32'h0);
		check("cfg", q, 32'h0);
		bus(1'b0, mcf_pkg::ADDR_PHASE, 32'h0);
		check("phase", q, 32'h0);
		bus(1'b1, 8'h0c, 32'hffffffff);
		bus(1'b0, 8'h0c, 32'h0);
		check("unmapped", q, 32'h0);
		// Full-scale DC, droop bypassed
		bus(1'b1, mcf_pkg::ADDR_CFG2, 32'h1);
		fresh(5);
		for (int p = 0; p < 4; p++) check("dc", res[4][p], 24'h200000);
		check("v_fan", res[4][2], res[4][0]);
		// Random offset and gain per path, saturation corner on path 0
		for (int p = 0; p < 4; p++) begin
			seed = xs(seed);
			offs[p] = p == 0 ? 24'h400000 : {{14{seed[9]}}, seed[9:0]};
			gains[p] = p == 0 ? 24'h7fffff : 24'h200000 + {3'h0, seed[30:10]};
			bus(1'b1, 8'h10 + 8'(4 * p), {8'h0, offs[p]});
			bus(1'b1, 8'h20 + 8'(4 * p), {8'h0, gains[p]});
		end
		bus(1'b0, 8'h24, 32'h0);
		fresh(2);
		for (int p = 0; p < 4; p++) check("corr", res[1][p], corr(24'h200000, offs[p], gains[p]));
		for (int p = 0; p < 4; p++) begin
			bus(1'b1, 8'h10 + 8'(4 * p), 32'h0);
			bus(1'b1, 8'h20 + 8'(4 * p), 32'h400000);
		end
		// Step: current 1 coarse 3 (clamps to 1) plus full fine, second voltage coarse two
		// Full fine code lands a whole word back, since integrators only step every 8 clocks
		bus(1'b1, mcf_pkg::ADDR_PHASE, 32'h0001ff2c);
		level <= 3'h0;
		fresh(4);
		level <= 3'h7;
		for (int j = 0; j < 8; j++) get_set(j);
		for (int j = 2; j < 8; j++) begin
			check("coarse_i", res[j][1], res[j-2][0]);
			check("coarse_v", res[j][2], res[j-2][0]);
			check("no_delay", res[j][3], res[j][0]);
			check("flat", 32'($signed(res[j][0]) > 24'sh200000), 0);
		end
		// Same step with droop correction on must overshoot
		bus(1'b1, mcf_pkg::ADDR_CFG2, 32'h0);
		bus(1'b1, mcf_pkg::ADDR_PHASE, 32'h0);
		level <= 3'h0;
		fresh(6);
		level <= 3'h7;
		n = 0;
		for (int j = 0; j < 8; j++) begin
			get_set(j);
			if ($signed(res[j][0]) > 24'sh200000) n++;
		end
		check("droop", 32'(n > 0), 1);
		// Modes: 3 none, phase match, 0 none, high-pass on path 3
		bus(1'b1, mcf_pkg::ADDR_CFG2, 32'h97);
		fresh(3);
		check("mode3", res[2][0], 24'h200000);
		check("mode0", res[2][2], 24'h200000);
		check("hpf", 32'($signed(res[2][3]) < 24'sh200000), 1);
		// Phase match keeps most of the level: input less fast mean plus slow mean
		check("pmf", 32'($signed(res[2][1]) > 24'sh100000 && $signed(res[2][1]) < 24'sh200000), 1);
		// First pair: phase match against high-pass; second pair high-pass on both
		bus(1'b1, mcf_pkg::ADDR_CFG2, 32'h000000ad);
		fresh(2);
		check("pair_pmf", 32'($signed(res[1][0]) > 24'sh100000 && $signed(res[1][0]) < 24'sh200000), 1);
		check("pair_hpf", 32'($signed(res[1][2]) < 24'sh200000), 1);
		// No reads for 11 sets: FIFO fills, overrun, then drain
		// Margin so the eleventh set has left the pipeline before status is read
		repeat (11 * 1024 + 64) @(posedge i_clk);
		bus(1'b0, mcf_pkg::ADDR_STATUS, 32'h0);
		check("overrun", q[1:0], 2'h3);
		fresh(0);
		check("depth", 32'(n inside {10, 11}), 1);
		bus(1'b1, mcf_pkg::ADDR_STATUS, 32'h2);
		bus(1'b0, mcf_pkg::ADDR_STATUS, 32'h0);
		check("ovr_clr", q[1], 1'b0);
		print_verdict();
	end
endmodule : mcf_path_tb
